//--- src/cbio_window_regs.sv
// I/O window, interrupt line/pin and bridge control registers of both
// functions of a CardBus bridge, plus the window forwarding decisions.
// Assumes configuration cycles are already decoded to function, dword
// and byte enables, and that I/O requests arrive synchronous to mclk.
`timescale 1ns/1ps

// How it works
// - Base bits 31-2 writable, bits 1-0 zero
// - Base upper half selects the 64K page
// - Windows decide forwarding in both directions
// - Window with zero base and limit claims nothing
// - Limit bits 15-2 writable within base page
// - Limit bits 31-16 read as zero
// - Limit low two bits compare as ones
// - Writes to read-only bits change nothing
// - Per-function interrupt line, resets to FFh
// - Interrupt pin value chosen per function
// - Tie bit set: both functions read 01h
// - Tie clear: function 0 01h, function 1 02h
// - Shared control bits live in function 0
// - Control bit 6 drives card reset, reset asserted
// - Control bits 8, 9 mark memory prefetchable
// - Bit 2 drops last 768 of each 1K in the low 64K from window claims
// - Bit 3 forwards legacy video addresses
module cbio_window_regs (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Configuration access
   input wire logic cfgWrEn,
   input wire logic cfgRdEn,
   input wire logic cfgFunc,
   input wire logic [5:0] cfgRegNum,
   input wire logic [3:0] cfgByteEn,
   input wire logic [31:0] cfgWdata,
   output logic [31:0] cfgRdata,
   output logic cfgRdValid,
   // System control
   input wire logic interruptTie,
   // Host-side I/O request
   input wire logic hostIoValid,
   input wire logic [31:0] hostIoAddr,
   // Card-side I/O request
   input wire logic cardIoValid,
   input wire logic cardIoFunc,
   input wire logic [31:0] cardIoAddr,
   // Forwarding decisions
   output logic [1:0] toCardClaim,
   output logic toHostPass,
   // Bridge control outputs, one bit per function
   output logic [1:0] cardReset,
   output logic [1:0] memWindow0Prefetchable,
   output logic [1:0] memWindow1Prefetchable,
   output logic [1:0] legacyIoRangeFilterEnable,
   output logic [1:0] videoLegacyForwardEnable
);

   localparam int NF = cbio_pkg::NUM_FUNC;
   localparam int NW = cbio_pkg::NUM_WIN;

   logic [31:0] ioBase_q [NF][NW];
   logic [31:0] ioLimit_q [NF][NW];
   logic [7:0] irqLine_q [NF];
   logic [15:0] bridgeCtl_q [NF];
   logic [15:0] ctlView [NF];
   logic [NW-1:0] hostHit [NF];
   logic [NW-1:0] cardHit [NF];
   logic [7:0] pinValue;
   logic [31:0] rdWord;
   logic [31:0] rdData_q;
   logic rdValid_q;
   logic [1:0] claim_d;
   logic [1:0] claim_q;
   logic pass_q;
   logic isCtlReg;
   logic [15:0] ctlWrMask;

   // Window compares, host and card side, per function and window
   for (genvar f = 0; f < NF; f++) begin : g_func
      for (genvar w = 0; w < NW; w++) begin : g_win
         cbio_window_match #(.AW(32)) u_host (
            .base(ioBase_q[f][w]),
            .limit(ioLimit_q[f][w]),
            .addr(hostIoAddr),
            .hit(hostHit[f][w])
         );
         cbio_window_match #(.AW(32)) u_card (
            .base(ioBase_q[f][w]),
            .limit(ioLimit_q[f][w]),
            .addr(cardIoAddr),
            .hit(cardHit[f][w])
         );
      end
   end

   // Register that holds line, pin and bridge control
   assign isCtlReg = cfgRegNum == cbio_pkg::regIndex(cbio_pkg::IRQ_LINE_OFS);

   // Function 1 may not touch the shared bits
   assign ctlWrMask = cfgFunc ?
      (cbio_pkg::BRIDGE_WR_MASK & ~cbio_pkg::BRIDGE_SHARED_MASK) :
      cbio_pkg::BRIDGE_WR_MASK;

   // Window base and limit registers
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         for (int f = 0; f < NF; f++) begin
            for (int w = 0; w < NW; w++) begin
               ioBase_q[f][w] <= cbio_pkg::IO_WIN_RST;
               ioLimit_q[f][w] <= cbio_pkg::IO_WIN_RST;
            end
         end
      end else if (cfgWrEn) begin
         for (int w = 0; w < NW; w++) begin
            if (cfgRegNum == cbio_pkg::regIndex(cbio_pkg::IO_BASE_OFS[w])) begin
               ioBase_q[cfgFunc][w] <= cbio_pkg::mergeBytes(
                  ioBase_q[cfgFunc][w], cfgWdata, cfgByteEn,
                  cbio_pkg::BASE_WR_MASK);
            end
            if (cfgRegNum == cbio_pkg::regIndex(cbio_pkg::IO_LIMIT_OFS[w])) begin
               ioLimit_q[cfgFunc][w] <= cbio_pkg::mergeBytes(
                  ioLimit_q[cfgFunc][w], cfgWdata, cfgByteEn,
                  cbio_pkg::LIMIT_WR_MASK);
            end
         end
      end
   end

   // Interrupt line, lane 0 of the dword
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         for (int f = 0; f < NF; f++) begin
            irqLine_q[f] <= cbio_pkg::IRQ_LINE_RST;
         end
      end else if (cfgWrEn && isCtlReg && cfgByteEn[0]) begin
         irqLine_q[cfgFunc] <= cfgWdata[7:0];
      end
   end

   // Bridge control, lanes 2 and 3 of the dword
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         for (int f = 0; f < NF; f++) begin
            bridgeCtl_q[f] <= cbio_pkg::BRIDGE_RST;
         end
      end else if (cfgWrEn && isCtlReg) begin
         bridgeCtl_q[cfgFunc] <= 16'(cbio_pkg::mergeBytes(
            {bridgeCtl_q[cfgFunc], 16'h0000}, cfgWdata, cfgByteEn,
            {ctlWrMask, 16'h0000}) >> 16);
      end
   end

   // Effective control: shared bits always from function 0
   always_comb begin
      ctlView[0] = bridgeCtl_q[0];
      ctlView[1] = (bridgeCtl_q[1] & ~cbio_pkg::BRIDGE_SHARED_MASK) |
         (bridgeCtl_q[0] & cbio_pkg::BRIDGE_SHARED_MASK);
   end

   // Interrupt pin follows the tie bit and the function
   assign pinValue = (cfgFunc && !interruptTie) ?
      cbio_pkg::PIN_INTB : cbio_pkg::PIN_INTA;

   // Read data selection; unmapped dwords read zero
   always_comb begin
      rdWord = '0;
      for (int w = 0; w < NW; w++) begin
         if (cfgRegNum == cbio_pkg::regIndex(cbio_pkg::IO_BASE_OFS[w])) begin
            rdWord = ioBase_q[cfgFunc][w];
         end
         if (cfgRegNum == cbio_pkg::regIndex(cbio_pkg::IO_LIMIT_OFS[w])) begin
            rdWord = ioLimit_q[cfgFunc][w];
         end
      end
      if (isCtlReg) begin
         rdWord = {ctlView[cfgFunc], pinValue, irqLine_q[cfgFunc]};
      end
   end

   // Registered read answer, one cycle after the request
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rdData_q <= '0;
         rdValid_q <= 1'b0;
      end else begin
         rdValid_q <= cfgRdEn;
         if (cfgRdEn) begin
            rdData_q <= rdWord;
         end
      end
   end

   assign cfgRdata = rdData_q;
   assign cfgRdValid = rdValid_q;

   // Host I/O claim per function: windows, legacy filter, video
   always_comb begin
      for (int f = 0; f < NF; f++) begin
         claim_d[f] = hostIoValid && (
            ((|hostHit[f]) &&
             !(ctlView[f][cbio_pkg::BC_LEGACY_FILTER_BIT] &&
               hostIoAddr[31:16] == 16'h0000 &&
               hostIoAddr[9:8] != 2'b00)) ||
            (ctlView[f][cbio_pkg::BC_VIDEO_FWD_BIT] &&
             cbio_pkg::isVideoAddr(hostIoAddr)));
      end
   end

   // Forwarding decisions, one cycle after the request
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         claim_q <= 2'b00;
         pass_q <= 1'b0;
      end else begin
         claim_q <= claim_d;
         pass_q <= cardIoValid && !(|cardHit[cardIoFunc]);
      end
   end

   assign toCardClaim = claim_q;
   assign toHostPass = pass_q;

   // Control bits out to the socket logic
   always_comb begin
      for (int f = 0; f < NF; f++) begin
         cardReset[f] = bridgeCtl_q[f][cbio_pkg::BC_CARD_RST_BIT];
         memWindow0Prefetchable[f] =
            bridgeCtl_q[f][cbio_pkg::BC_PREF0_BIT];
         memWindow1Prefetchable[f] =
            bridgeCtl_q[f][cbio_pkg::BC_PREF1_BIT];
         legacyIoRangeFilterEnable[f] =
            bridgeCtl_q[f][cbio_pkg::BC_LEGACY_FILTER_BIT];
         videoLegacyForwardEnable[f] =
            bridgeCtl_q[f][cbio_pkg::BC_VIDEO_FWD_BIT];
      end
   end

   // Checks on register contents and forwarding
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   base_low_zero_a: assert property (
      ioBase_q[0][0][1:0] == 2'b00 && ioBase_q[0][1][1:0] == 2'b00 &&
      ioBase_q[1][0][1:0] == 2'b00 && ioBase_q[1][1][1:0] == 2'b00)
      else $error("window base low bits not zero");

   base_write_a: assert property (
      cfgWrEn && !cfgFunc && cfgByteEn == 4'hf &&
      cfgRegNum == cbio_pkg::regIndex(cbio_pkg::IO_BASE_OFS[0])
      |=> ioBase_q[0][0] == ($past(cfgWdata) & cbio_pkg::BASE_WR_MASK))
      else $error("window base write not masked");

   limit_page_zero_a: assert property (
      ioLimit_q[0][0][31:16] == 16'h0000 &&
      ioLimit_q[1][1][31:16] == 16'h0000 &&
      ioLimit_q[0][1][1:0] == 2'b00)
      else $error("limit read-only bits not zero");

   irq_line_rst_a: assert property (
      $past(sys_rst) |->
      irqLine_q[0] == cbio_pkg::IRQ_LINE_RST &&
      irqLine_q[1] == cbio_pkg::IRQ_LINE_RST)
      else $error("interrupt line not FFh after reset");

   bridge_rst_a: assert property (
      $past(sys_rst) |->
      bridgeCtl_q[0] == cbio_pkg::BRIDGE_RST && cardReset == 2'b11)
      else $error("bridge control not 0340h after reset");

   pin_tied_a: assert property (
      cfgRdEn && isCtlReg && interruptTie
      |=> cfgRdValid && cfgRdata[15:8] == cbio_pkg::PIN_INTA)
      else $error("tied pin not 01h");

   pin_split_a: assert property (
      cfgRdEn && isCtlReg && !interruptTie
      |=> cfgRdata[15:8] == ($past(cfgFunc) ?
         cbio_pkg::PIN_INTB : cbio_pkg::PIN_INTA))
      else $error("untied pin value wrong");

   zero_window_a: assert property (
      hostIoValid && ioBase_q[1][0] == '0 && ioLimit_q[1][0] == '0 &&
      ioBase_q[1][1] == '0 && ioLimit_q[1][1] == '0 &&
      !ctlView[1][cbio_pkg::BC_VIDEO_FWD_BIT] |=> !toCardClaim[1])
      else $error("zeroed windows claimed a cycle");

   window_top_a: assert property (
      hostIoValid && ioBase_q[0][0] != '0 &&
      (!ctlView[0][cbio_pkg::BC_LEGACY_FILTER_BIT] ||
       hostIoAddr[31:16] != 16'h0000) &&
      ioBase_q[0][0][15:0] <= {ioLimit_q[0][0][15:2], 2'b11} &&
      hostIoAddr == {ioBase_q[0][0][31:16], ioLimit_q[0][0][15:2], 2'b11}
      |=> toCardClaim[0])
      else $error("window top address not claimed");

   legacy_filter_a: assert property (
      hostIoValid && ctlView[0][cbio_pkg::BC_LEGACY_FILTER_BIT] &&
      !(ctlView[0][cbio_pkg::BC_VIDEO_FWD_BIT] &&
        cbio_pkg::isVideoAddr(hostIoAddr)) &&
      hostIoAddr[31:16] == 16'h0000 && hostIoAddr[9:8] != 2'b00
      |=> !toCardClaim[0])
      else $error("legacy alias range was forwarded");

   video_claim_a: assert property (
      hostIoValid && ctlView[0][cbio_pkg::BC_VIDEO_FWD_BIT] &&
      cbio_pkg::isVideoAddr(hostIoAddr)
      |=> toCardClaim[0])
      else $error("legacy video address not claimed");

   card_pass_a: assert property (
      cardIoValid && !cardIoFunc && (|cardHit[0])
      |=> !toHostPass)
      else $error("card cycle inside a window passed upstream");

   limit_write_a: assert property (
      cfgWrEn && cfgFunc && cfgByteEn == 4'hf &&
      cfgRegNum == cbio_pkg::regIndex(cbio_pkg::IO_LIMIT_OFS[1])
      |=> ioLimit_q[1][1] == ($past(cfgWdata) & cbio_pkg::LIMIT_WR_MASK))
      else $error("window limit write not masked");

   ctl_ro_zero_a: assert property (
      (bridgeCtl_q[0] & ~cbio_pkg::BRIDGE_WR_MASK) == 16'h0000 &&
      (bridgeCtl_q[1] & ~cbio_pkg::BRIDGE_WR_MASK) == 16'h0000)
      else $error("bridge control read-only bits set");

   card_reset_a: assert property (
      cfgWrEn && !cfgFunc && isCtlReg && cfgByteEn[2]
      |=> cardReset[0] == $past(cfgWdata[16 + cbio_pkg::BC_CARD_RST_BIT]))
      else $error("card reset does not follow bit 6");

   shared_bits_a: assert property (
      cfgWrEn && cfgFunc && isCtlReg
      |=> $stable(bridgeCtl_q[0]) &&
         (bridgeCtl_q[1] & cbio_pkg::BRIDGE_SHARED_MASK) == 16'h0000)
      else $error("function 1 changed shared control bits");

   // Main scenarios
   claim_seen_c: cover property (hostIoValid ##1 toCardClaim[0]);
   pass_seen_c: cover property (cardIoValid ##1 toHostPass);
   tie_read_c: cover property (cfgRdEn && isCtlReg && cfgFunc && interruptTie);
   video_claim_c: cover property (hostIoValid &&
      cbio_pkg::isVideoAddr(hostIoAddr) ##1 toCardClaim[0]);

endmodule // cbio_window_regs

//--- shared/cbio_pkg.sv
// Constants, layouts and helpers of the CardBus I/O window register bank.
// Assumes byte-enabled dword configuration access, one function per socket.
package cbio_pkg;

   // Function and window counts
   localparam int NUM_FUNC = 2;
   localparam int NUM_WIN = 2;

   // Configuration byte offsets
   localparam logic [7:0] IO_BASE_OFS [NUM_WIN] = '{8'h2c, 8'h34};
   localparam logic [7:0] IO_LIMIT_OFS [NUM_WIN] = '{8'h30, 8'h38};
   localparam logic [7:0] IRQ_LINE_OFS = 8'h3c;
   localparam logic [7:0] IRQ_PIN_OFS = 8'h3d;
   localparam logic [7:0] BRIDGE_CTL_OFS = 8'h3e;

   // Writable bits and values after reset
   localparam logic [31:0] BASE_WR_MASK = 32'hffff_fffc;
   localparam logic [31:0] LIMIT_WR_MASK = 32'h0000_fffc;
   localparam logic [15:0] BRIDGE_WR_MASK = 16'h07ef;
   localparam logic [15:0] BRIDGE_SHARED_MASK = 16'h0023;
   localparam logic [15:0] BRIDGE_RST = 16'h0340;
   localparam logic [31:0] IO_WIN_RST = 32'h0000_0000;
   localparam logic [7:0] IRQ_LINE_RST = 8'hff;

   // Interrupt pin answers
   localparam logic [7:0] PIN_INTA = 8'h01;
   localparam logic [7:0] PIN_INTB = 8'h02;

   // Bridge control bit positions
   localparam int BC_LEGACY_FILTER_BIT = 2;
   localparam int BC_VIDEO_FWD_BIT = 3;
   localparam int BC_CARD_RST_BIT = 6;
   localparam int BC_PREF0_BIT = 8;
   localparam int BC_PREF1_BIT = 9;

   // Legacy video I/O ranges
   localparam logic [31:0] VIDEO_LO0 = 32'h0000_03b0;
   localparam logic [31:0] VIDEO_HI0 = 32'h0000_03bb;
   localparam logic [31:0] VIDEO_LO1 = 32'h0000_03c0;
   localparam logic [31:0] VIDEO_HI1 = 32'h0000_03df;

   // Dword index of a byte offset
   function automatic logic [5:0] regIndex(input logic [7:0] ofs);
      return ofs[7:2];
   endfunction

   // Byte-lane write merge; bits outside mask keep their old value
   function automatic logic [31:0] mergeBytes(input logic [31:0] old,
      input logic [31:0] wdata, input logic [3:0] be,
      input logic [31:0] mask);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = (wdata[i*8 +: 8] & mask[i*8 +: 8]) |
               (old[i*8 +: 8] & ~mask[i*8 +: 8]);
         end
      end
      return res;
   endfunction

   // Legacy video adapter I/O address
   function automatic logic isVideoAddr(input logic [31:0] a);
      return (a >= VIDEO_LO0 && a <= VIDEO_HI0) ||
         (a >= VIDEO_LO1 && a <= VIDEO_HI1);
   endfunction

endpackage

//--- src/cbio_window_match.sv
// One I/O window address compare.
// Assumes base and limit come straight from their registers.
`timescale 1ns/1ps

module cbio_window_match #(
   parameter int AW = 32
) (
   // Window registers
   input wire logic [AW-1:0] base,
   input wire logic [AW-1:0] limit,
   // Address under test
   input wire logic [AW-1:0] addr,
   // Result
   output logic hit
);

   logic enabled;
   logic [AW-1:0] top;

   // Window live only once either register is nonzero
   assign enabled = (base != '0) || (limit != '0);
   // Top takes its page from the base, low two bits as ones
   assign top = {base[AW-1:16], limit[15:2], 2'b11};
   // Inclusive compare on both ends
   assign hit = enabled && (addr >= base) && (addr <= top);

endmodule // cbio_window_match

//--- verif/cbio_card_model.sv
// Card-side I/O requester standing beyond the bridge.
// Assumes the bench orders one request per one-cycle go pulse.
`timescale 1ns/1ps

module cbio_card_model (
   // Clock
   input wire logic mclk,
   // Request orders from the bench
   input wire logic go,
   input wire logic goFunc,
   input wire logic [31:0] goAddr,
   // Card cycle toward the bridge
   output logic cardIoValid,
   output logic cardIoFunc,
   output logic [31:0] cardIoAddr
);
   // Quiet lines at time zero
   initial begin
      cardIoValid = 1'b0;
      cardIoFunc = 1'b0;
      cardIoAddr = 32'h0000_0000;
   end

   // One cycle per order; idle lines flip so stale values never match
   always @(posedge mclk) begin
      cardIoValid <= go;
      cardIoFunc <= go ? goFunc : ~cardIoFunc;
      cardIoAddr <= go ? goAddr : ~cardIoAddr;
   end
endmodule // cbio_card_model

//--- verif/cbio_window_regs_tb.sv
// Self-checking bench of the CardBus I/O window register bank.
// Assumes the card model drives the card-side request pins.
`timescale 1ns/1ps

module cbio_window_regs_tb;
   logic mclk, sysRst, cfgWrEn, cfgRdEn, cfgFunc, interruptTie;
   logic cfgRdValid, hostIoValid, cardIoValid, cardIoFunc, toHostPass;
   logic go, goFunc, hostD, cardD, rf;
   logic [5:0] cfgRegNum, ri;
   logic [3:0] cfgByteEn;
   logic [31:0] cfgWdata, cfgRdata, hostIoAddr, cardIoAddr, goAddr, rnd;
   logic [1:0] toCardClaim, cardReset, pref0, pref1, filt, video;
   logic [31:0] m [2][64];
   logic [31:0] rdQ [$];
   logic [1:0] claimQ [$];
   logic passQ [$];
   int nFail, comparisons;

   // Block and its card-side partner
   cbio_window_regs dut (.mclk(mclk), .sys_rst(sysRst), .cfgWrEn(cfgWrEn),
      .cfgRdEn(cfgRdEn), .cfgFunc(cfgFunc), .cfgRegNum(cfgRegNum),
      .cfgByteEn(cfgByteEn), .cfgWdata(cfgWdata), .cfgRdata(cfgRdata),
      .cfgRdValid(cfgRdValid), .interruptTie(interruptTie),
      .hostIoValid(hostIoValid), .hostIoAddr(hostIoAddr),
      .cardIoValid(cardIoValid), .cardIoFunc(cardIoFunc),
      .cardIoAddr(cardIoAddr), .toCardClaim(toCardClaim),
      .toHostPass(toHostPass), .cardReset(cardReset),
      .memWindow0Prefetchable(pref0), .memWindow1Prefetchable(pref1),
      .legacyIoRangeFilterEnable(filt), .videoLegacyForwardEnable(video));
   cbio_card_model card (.mclk(mclk), .go(go), .goFunc(goFunc),
      .goAddr(goAddr), .cardIoValid(cardIoValid), .cardIoFunc(cardIoFunc),
      .cardIoAddr(cardIoAddr));

   // Clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // Writable bits of each dword
   function automatic logic [31:0] wrMask(input logic f, input logic [5:0] i);
      case (i)
         6'h0b, 6'h0d: return 32'hffff_fffc;
         6'h0c, 6'h0e: return 32'h0000_fffc;
         6'h0f: return {f ? 16'h07cc : 16'h07ef, 16'h00ff};
         default: return 32'h0000_0000;
      endcase
   endfunction

   function automatic logic [31:0] expRd(input logic f, input logic [5:0] i);
      logic [15:0] c;
      logic [7:0] pin;
      c = f ? (m[1][15][31:16] & 16'hffdc) | (m[0][15][31:16] & 16'h0023)
         : m[0][15][31:16];
      pin = (f && !interruptTie) ? 8'h02 : 8'h01;
      return (i == 6'h0f) ? {c, pin, m[f][15][7:0]} : m[f][i];
   endfunction

   function automatic logic hitW(input logic f, input int w,
      input logic [31:0] a);
      logic [31:0] b, l, t;
      b = m[f][11 + 2 * w];
      l = m[f][12 + 2 * w];
      t = {b[31:16], l[15:2], 2'b11};
      return (b != 0 || l != 0) && a >= b && a <= t;
   endfunction

   function automatic logic [1:0] expClaim(input logic [31:0] a);
      logic [1:0] r;
      logic [15:0] c;
      logic v;
      v = (a >= 32'h0000_03b0 && a <= 32'h0000_03bb) ||
         (a >= 32'h0000_03c0 && a <= 32'h0000_03df);
      for (int f = 0; f < 2; f++) begin
         c = m[f][15][31:16];
         r[f] = (c[3] && v) || ((hitW(f, 0, a) || hitW(f, 1, a)) &&
            !(c[2] && a[31:16] == 16'h0000 && a[9:8] != 2'b00));
      end
      return r;
   endfunction

   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         nFail++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask

   // One compare task per kind of result
   task automatic chkRd(input logic [31:0] e, input logic [31:0] g);
      chk("cfgRdata", e, g);
   endtask

   task automatic chkClaim(input logic [1:0] e, input logic [1:0] g);
      chk("toCardClaim", 32'(e), 32'(g));
   endtask

   task automatic chkPass(input logic e, input logic g);
      chk("toHostPass", 32'(e), 32'(g));
   endtask

   task automatic wr(input logic f, input logic [5:0] i, input logic [3:0] be,
      input logic [31:0] d);
      logic [31:0] k;
      k = wrMask(f, i);
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            m[f][i][b*8 +: 8] = (d[b*8 +: 8] & k[b*8 +: 8]) |
               (m[f][i][b*8 +: 8] & ~k[b*8 +: 8]);
         end
      end
      @(posedge mclk);
      cfgWrEn <= 1'b1;
      cfgFunc <= f;
      cfgRegNum <= i;
      cfgByteEn <= be;
      cfgWdata <= d;
      @(posedge mclk);
      cfgWrEn <= 1'b0;
   endtask

   task automatic rd(input logic f, input logic [5:0] i);
      @(posedge mclk);
      rdQ.push_back(expRd(f, i));
      cfgRdEn <= 1'b1;
      cfgFunc <= f;
      cfgRegNum <= i;
      @(posedge mclk);
      cfgRdEn <= 1'b0;
   endtask

   task automatic io(input logic [31:0] a, input logic f);
      @(posedge mclk);
      claimQ.push_back(expClaim(a));
      passQ.push_back(!(hitW(f, 0, a) || hitW(f, 1, a)));
      hostIoValid <= 1'b1;
      hostIoAddr <= a;
      go <= 1'b1;
      goFunc <= f;
      goAddr <= a;
      @(posedge mclk);
      hostIoValid <= 1'b0;
      hostIoAddr <= ~a;
      go <= 1'b0;
   endtask

   task automatic ctlChk;
      logic [15:0] c0, c1;
      @(negedge mclk);
      c0 = m[0][15][31:16];
      c1 = m[1][15][31:16];
      chk("cardReset", {c1[6], c0[6]}, cardReset);
      chk("pref0", {c1[8], c0[8]}, pref0);
      chk("pref1", {c1[9], c0[9]}, pref1);
      chk("filter", {c1[2], c0[2]}, filt);
      chk("video", {c1[3], c0[3]}, video);
   endtask

   task automatic summarize;
      if (nFail == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Result watcher: every result takes the oldest note of its kind
   always @(negedge mclk) begin
      if (cfgRdValid === 1'b1) begin
         chkRd(rdQ.size() > 0 ? rdQ.pop_front() : 'x, cfgRdata);
      end
      chkClaim(hostD ? claimQ.pop_front() : 2'b00, toCardClaim);
      chkPass(cardD ? passQ.pop_front() : 1'b0, toHostPass);
      hostD = hostIoValid;
      cardD = cardIoValid;
   end

   // Watchdog
   initial begin
      #400000;
      nFail++;
      summarize();
   end

   // Main sequence
   initial begin
      {sysRst, hostD, cardD} = 3'b100;
      {cfgWrEn, cfgRdEn, cfgFunc, interruptTie, hostIoValid, go} = 6'h00;
      {goFunc, cfgRegNum, cfgByteEn} = 11'h000;
      {cfgWdata, hostIoAddr, goAddr} = 96'h0;
      rnd = 32'd83061;
      for (int f = 0; f < 2; f++) begin
         for (int i = 0; i < 64; i++) begin
            m[f][i] = (i == 15) ? 32'h0340_00ff : 32'h0000_0000;
         end
      end
      repeat (3) @(posedge mclk);
      sysRst <= 1'b0;
      // Reset values, unmapped neighbours, then all ones
      for (int f = 0; f < 2; f++) begin
         for (int i = 10; i < 17; i++) rd(f, 6'(i));
      end
      ctlChk();
      for (int f = 0; f < 2; f++) begin
         for (int i = 10; i < 17; i++) wr(f, 6'(i), 4'hf, 32'hffff_ffff);
         for (int i = 10; i < 17; i++) rd(f, 6'(i));
      end
      ctlChk();
      // Random lanes, data and tie bit
      repeat (40) begin
         rnd = lfsr(rnd);
         rf = rnd[0];
         ri = 6'h0b + 6'(rnd[3:1] % 3'd5);
         wr(rf, ri, rnd[7:4], lfsr(rnd));
         @(posedge mclk);
         interruptTie <= rnd[8];
         rd(rf, ri);
         rd(~rf, 6'h0f);
      end
      // Windows: f0 page 1 and low page, f1 left empty
      wr(0, 6'h0b, 4'hf, 32'h0001_2340);
      wr(0, 6'h0c, 4'hf, 32'hffff_5678);
      wr(0, 6'h0d, 4'hf, 32'h0000_0000);
      wr(0, 6'h0e, 4'hf, 32'h0000_fffc);
      wr(0, 6'h0f, 4'hc, 32'h000c_0000);
      for (int i = 11; i < 16; i++) wr(1, 6'(i), 4'hf, 32'h0000_0000);
      ctlChk();
      for (int i = 0; i < 11; i++) begin
         io(32'h0001_233f + 32'(i) * 32'h0000_3339, i[0]);
      end
      for (int f = 0; f < 2; f++) begin
         io(32'h0001_2340, f);
         io(32'h0001_567b, f);
         io(32'h0001_567c, f);
         io(32'h0000_0100, f);
         io(32'h0000_0400, f);
         io(32'h0000_03b0, f);
         io(32'h0000_03e0, f);
      end
      repeat (60) begin
         rnd = lfsr(rnd);
         io(rnd & 32'h0001_ffff, rnd[20]);
      end
      repeat (4) @(negedge mclk);
      summarize();
   end
endmodule // cbio_window_regs_tb
